// *** core/spr_router.sv ***
// packet router: crossbar, routing table, config port, time-codes
module spr_router (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // link character side, receive
    input wire logic [spr_pkg::NL-1:0][spr_pkg::WW-1:0] link_rx_word,
    input wire logic [spr_pkg::NL-1:0] link_rx_valid,
    output logic [spr_pkg::NL-1:0] link_rx_ready,
    // link character side, transmit
    output logic [spr_pkg::NL-1:0][spr_pkg::WW-1:0] link_tx_word,
    output logic [spr_pkg::NL-1:0] link_tx_valid,
    input wire logic [spr_pkg::NL-1:0] link_tx_ready,
    output logic [spr_pkg::NL-1:0] link_tx_oe_n,
    // link control and status
    output logic [spr_pkg::NL-1:0] link_enable,
    input wire logic [spr_pkg::NL-1:0] link_error,
    output logic [spr_pkg::NL-1:0] link_error_status,
    // link time-codes
    input wire logic [spr_pkg::NL-1:0] link_tc_rx_valid,
    input wire logic [spr_pkg::NL-1:0][spr_pkg::TW-1:0] link_tc_rx_value,
    output logic [spr_pkg::NL-1:0] link_tc_tx_valid,
    output logic [spr_pkg::TW-1:0] link_tc_tx_value,
    // external time interface
    input wire logic tick_in,
    input wire logic [spr_pkg::TW-1:0] time_in,
    output logic tick_out,
    output logic [spr_pkg::TW-1:0] time_out,
    // host input FIFOs
    input wire logic [spr_pkg::NH-1:0] host_tx_fifo_push_n,
    input wire logic [spr_pkg::NH-1:0][spr_pkg::WW-1:0] host_tx_fifo_word,
    output logic [spr_pkg::NH-1:0] host_tx_fifo_has_room_n,
    // host output FIFOs
    input wire logic [spr_pkg::NH-1:0] host_rx_fifo_pop_n,
    output logic [spr_pkg::NH-1:0][spr_pkg::WW-1:0] host_rx_fifo_word,
    output logic [spr_pkg::NH-1:0] host_rx_fifo_has_word_n,
    // configuration status
    output logic cfg_error
);
    localparam int NP = spr_pkg::NP;
    localparam int PW = spr_pkg::PW;
    localparam int NL = spr_pkg::NL;
    localparam int WW = spr_pkg::WW;
    localparam int TW = spr_pkg::TW;
    localparam int L0 = spr_pkg::LINK0;
    localparam int H0 = spr_pkg::HOST0;
    localparam int MB = spr_pkg::MARK_BIT;
    localparam int LW = $clog2(NL);

    typedef struct packed {
        spr_pkg::spr_in_st_t [NP-1:0] st;
        logic [NP-1:0][NP-1:0] want;
        logic [NP-1:0] pri;
        logic [NP-1:0][PW-1:0] dst;
        logic [NP-1:0] busy;
        logic [NP-1:0][PW-1:0] src;
        spr_pkg::spr_rt_t [spr_pkg::RT_N-1:0] rt;
        logic [NL-1:0] link_dis;
        logic [NL-1:0] link_err;
        logic cfg_err;
        logic [2:0] cfg_cnt;
        logic [3:0][7:0] cfg_b;
        logic tm_master;
        logic tm_auto;
        logic [TW-1:0] time_reg;
        logic tick_s1;
        logic tick_s2;
        logic tick_d;
        logic [TW-1:0] tin_s1;
        logic [TW-1:0] tin_s2;
        logic tick_out;
        logic [NL-1:0] tc_tx;
    } spr_router_st_t;

    spr_router_st_t r_reg;
    spr_router_st_t r_next;

    wire [NP-1:0][WW-1:0] src_word;
    wire [NP-1:0] src_valid;
    logic [NP-1:0] src_ready;
    logic [NP-1:0][WW-1:0] snk_word;
    logic [NP-1:0] snk_valid;
    wire [NP-1:0] snk_ready;
    logic [NP-1:0][NP-1:0] req_hi;
    logic [NP-1:0][NP-1:0] req_lo;
    logic [NP-1:0] rel;
    wire [NP-1:0] gnt;
    wire [NP-1:0][PW-1:0] gnt_idx;
    spr_pkg::spr_rt_t rte;
    logic [PW:0] pick;
    logic [PW-1:0] s;
    logic [PW-1:0] d;
    logic [WW-1:0] w;
    logic ok;
    logic [LW-1:0] li;
    logic found;
    logic [LW-1:0] lsel;

    // header decode: path address, or logical address via table
    function automatic spr_pkg::spr_rt_t spr_route(input logic [7:0] h, input spr_pkg::spr_rt_t ent);
        spr_pkg::spr_rt_t res;
        res = '0;
        if (int'(h) <= spr_pkg::PATH_MAX) begin
            res.valid = 1'b1;
            res.del = 1'b1;
            res.mask[h[PW-1:0]] = 1'b1;
        end else if (int'(h) >= spr_pkg::LOGICAL_MIN) begin
            res = ent;
        end
        return res;
    endfunction

    // lowest set bit of a port set
    function automatic logic [PW:0] spr_first(input logic [NP-1:0] m);
        logic [PW:0] res;
        res = '0;
        for (int k = NP - 1; k >= 0; k--) begin
            if (m[k]) begin
                res = {1'b1, k[PW-1:0]};
            end
        end
        return res;
    endfunction

    // port index maps to a link with its error raised
    function automatic logic spr_lerr(input int p, input logic [NL-1:0] e);
        return p >= L0 && p < L0 + NL && e[p - L0];
    endfunction

    function automatic logic [TW-1:0] spr_tnext(input logic [TW-1:0] t);
        return t + 1'b1;
    endfunction

    // port wiring: config sink is port 0 and never sources
    assign src_valid[0] = 1'b0;
    assign src_word[0] = '0;
    assign snk_ready[0] = 1'b1;
    for (genvar l = 0; l < NL; l++) begin : g_link
        assign src_valid[L0+l] = link_rx_valid[l] & ~r_reg.link_dis[l];
        assign src_word[L0+l] = link_rx_word[l];
        // disabled link drains and sinks so no path stalls on it
        assign link_rx_ready[l] = src_ready[L0+l] | r_reg.link_dis[l];
        assign snk_ready[L0+l] = link_tx_ready[l] | r_reg.link_dis[l];
        assign link_tx_valid[l] = snk_valid[L0+l] & ~r_reg.link_dis[l];
        assign link_tx_word[l] = snk_word[L0+l];
    end
    for (genvar h = 0; h < spr_pkg::NH; h++) begin : g_host
        spr_fifo u_in (
            .mclk(mclk),
            .arst_n(arst_n),
            .in_valid(~host_tx_fifo_push_n[h]),
            .in_ready(host_tx_fifo_has_room_n[h]),
            .in_word(host_tx_fifo_word[h]),
            .out_valid(src_valid[H0+h]),
            .out_ready(src_ready[H0+h]),
            .out_word(src_word[H0+h])
        );
        spr_fifo u_out (
            .mclk(mclk),
            .arst_n(arst_n),
            .in_valid(snk_valid[H0+h]),
            .in_ready(snk_ready[H0+h]),
            .in_word(snk_word[H0+h]),
            .out_valid(host_rx_fifo_has_word_n[h]),
            .out_ready(~host_rx_fifo_pop_n[h]),
            .out_word(host_rx_fifo_word[h])
        );
    end
    for (genvar o = 0; o < NP; o++) begin : g_arb
        spr_arb u_arb (
            .mclk(mclk),
            .arst_n(arst_n),
            .req_hi(req_hi[o]),
            .req_lo(req_lo[o]),
            .free(~r_reg.busy[o]),
            .rel(rel[o]),
            .rel_src(r_reg.src[o]),
            .gnt(gnt[o]),
            .gnt_idx(gnt_idx[o])
        );
    end

    always_comb begin
        r_next = r_reg;
        r_next.tick_out = 1'b0;
        r_next.tc_tx = '0;
        r_next.tick_s1 = tick_in;
        r_next.tick_s2 = r_reg.tick_s1;
        r_next.tick_d = r_reg.tick_s2;
        r_next.tin_s1 = time_in;
        r_next.tin_s2 = r_reg.tin_s1;
        src_ready = '0;
        snk_valid = '0;
        snk_word = '0;
        req_hi = '0;
        req_lo = '0;
        rel = '0;
        rte = '0;
        pick = '0;
        s = '0;
        d = '0;
        w = '0;
        ok = 1'b0;
        li = '0;
        found = 1'b0;
        lsel = '0;
        // crossbar: each busy output follows its own source
        for (int o = 0; o < NP; o++) begin
            if (r_reg.busy[o]) begin
                s = r_reg.src[o];
                if (r_reg.st[s] == spr_pkg::IN_EEP) begin
                    snk_valid[o] = 1'b1;
                    snk_word[o] = spr_pkg::EEP_WORD;
                end else begin
                    snk_valid[o] = src_valid[s];
                    snk_word[o] = src_word[s];
                end
            end
        end
        for (int i = 1; i < NP; i++) begin
            d = r_reg.dst[i];
            unique case (r_reg.st[i])
                spr_pkg::IN_HEAD: begin
                    if (src_valid[i]) begin
                        rte = spr_route(src_word[i][7:0], r_reg.rt[src_word[i][7:0]]);
                        if (src_word[i][MB]) begin
                            // empty packet: marker alone is dropped
                            src_ready[i] = 1'b1;
                        end else if (!rte.valid || rte.mask == '0) begin
                            r_next.st[i] = spr_pkg::IN_SPILL;
                        end else begin
                            src_ready[i] = rte.del;
                            r_next.want[i] = rte.mask;
                            r_next.pri[i] = rte.pri;
                            r_next.st[i] = spr_pkg::IN_REQ;
                        end
                    end
                end
                spr_pkg::IN_REQ: begin
                    // request only one free member so grants never collide
                    pick = spr_first(r_reg.want[i] & ~r_reg.busy);
                    if (pick[PW] && r_reg.pri[i]) begin
                        req_hi[pick[PW-1:0]][i] = 1'b1;
                    end else if (pick[PW]) begin
                        req_lo[pick[PW-1:0]][i] = 1'b1;
                    end
                end
                spr_pkg::IN_XFER: begin
                    src_ready[i] = snk_ready[d];
                    if (spr_lerr(i, link_error)) begin
                        r_next.st[i] = spr_pkg::IN_EEP;
                    end else if (spr_lerr(int'(d), link_error)) begin
                        r_next.st[i] = spr_pkg::IN_SPILL;
                        r_next.busy[d] = 1'b0;
                        rel[d] = 1'b1;
                    end else if (src_valid[i] && snk_ready[d] && src_word[i][MB]) begin
                        r_next.st[i] = spr_pkg::IN_HEAD;
                        r_next.busy[d] = 1'b0;
                        rel[d] = 1'b1;
                    end
                end
                spr_pkg::IN_EEP: begin
                    if (snk_ready[d]) begin
                        r_next.st[i] = spr_pkg::IN_HEAD;
                        r_next.busy[d] = 1'b0;
                        rel[d] = 1'b1;
                    end
                end
                spr_pkg::IN_SPILL: begin
                    src_ready[i] = 1'b1;
                    if (src_valid[i] && src_word[i][MB]) begin
                        r_next.st[i] = spr_pkg::IN_HEAD;
                    end
                end
            endcase
        end
        for (int o = 0; o < NP; o++) begin
            if (gnt[o]) begin
                r_next.busy[o] = 1'b1;
                r_next.src[o] = gnt_idx[o];
                r_next.st[gnt_idx[o]] = spr_pkg::IN_XFER;
                r_next.dst[gnt_idx[o]] = o[PW-1:0];
            end
        end
        // configuration port command parser
        if (snk_valid[0]) begin
            w = snk_word[0];
            li = r_reg.cfg_b[1][LW-1:0];
            if (w[MB]) begin
                r_next.cfg_cnt = '0;
                case (r_reg.cfg_b[0])
                    spr_pkg::CMD_RT: ok = r_reg.cfg_cnt == spr_pkg::LEN_RT;
                    spr_pkg::CMD_LINK: ok = r_reg.cfg_cnt == spr_pkg::LEN_LINK && int'(r_reg.cfg_b[1]) < NL;
                    spr_pkg::CMD_CLR: ok = r_reg.cfg_cnt == spr_pkg::LEN_CLR && int'(r_reg.cfg_b[1]) < NL;
                    spr_pkg::CMD_TIME: ok = r_reg.cfg_cnt == spr_pkg::LEN_TIME;
                    spr_pkg::CMD_CLR_CFG: ok = r_reg.cfg_cnt == spr_pkg::LEN_CFG;
                    default: ok = 1'b0;
                endcase
                if (!ok || w[spr_pkg::EEP_BIT]) begin
                    r_next.cfg_err = 1'b1;
                end else begin
                    case (r_reg.cfg_b[0])
                        spr_pkg::CMD_RT: begin
                            r_next.rt[r_reg.cfg_b[1]] = {r_reg.cfg_b[2][spr_pkg::FL_VALID],
                                r_reg.cfg_b[2][spr_pkg::FL_PRI], r_reg.cfg_b[2][spr_pkg::FL_DEL],
                                r_reg.cfg_b[2][spr_pkg::MASK_HI:0], r_reg.cfg_b[3]};
                        end
                        spr_pkg::CMD_LINK: r_next.link_dis[li] = ~r_reg.cfg_b[2][spr_pkg::LINK_EN_BIT];
                        spr_pkg::CMD_CLR: r_next.link_err[li] = 1'b0;
                        spr_pkg::CMD_TIME: begin
                            r_next.tm_master = r_reg.cfg_b[1][spr_pkg::TM_MASTER];
                            r_next.tm_auto = r_reg.cfg_b[1][spr_pkg::TM_AUTO];
                        end
                        spr_pkg::CMD_CLR_CFG: r_next.cfg_err = 1'b0;
                        default: r_next.cfg_err = r_reg.cfg_err;
                    endcase
                end
            end else begin
                if (r_reg.cfg_cnt < spr_pkg::LEN_RT) begin
                    r_next.cfg_b[r_reg.cfg_cnt[1:0]] = w[7:0];
                end
                if (r_reg.cfg_cnt != spr_pkg::CNT_MAX) begin
                    r_next.cfg_cnt = r_reg.cfg_cnt + 3'h1;
                end
            end
        end
        // a new error beats a clear in the same cycle
        r_next.link_err = r_next.link_err | link_error;
        // time-codes: master on synchronised tick-in edge, else slave
        if (r_reg.tm_master) begin
            if (r_reg.tick_s2 && !r_reg.tick_d) begin
                r_next.time_reg = r_reg.tm_auto ? spr_tnext(r_reg.time_reg) : r_reg.tin_s2;
                r_next.tick_out = 1'b1;
                r_next.tc_tx = ~r_reg.link_dis;
            end
        end else begin
            for (int l = NL - 1; l >= 0; l--) begin
                if (link_tc_rx_valid[l] && !r_reg.link_dis[l]) begin
                    found = 1'b1;
                    lsel = l[LW-1:0];
                end
            end
            if (found) begin
                r_next.time_reg = link_tc_rx_value[lsel];
                if (link_tc_rx_value[lsel] == spr_tnext(r_reg.time_reg)) begin
                    r_next.tick_out = 1'b1;
                    r_next.tc_tx = ~r_reg.link_dis;
                    r_next.tc_tx[lsel] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link_enable = ~r_reg.link_dis;
    assign link_tx_oe_n = r_reg.link_dis;
    assign link_error_status = r_reg.link_err;
    assign link_tc_tx_valid = r_reg.tc_tx;
    assign link_tc_tx_value = r_reg.time_reg;
    assign tick_out = r_reg.tick_out;
    assign time_out = r_reg.time_reg;
    assign cfg_error = r_reg.cfg_err;
endmodule

// *** core/spr_pkg.sv ***
// shared constants and types for the packet router
// Operation
// - eight independent serial links, each with own control and status bits
// - host ports move nine-bit words through input and output FIFOs on mclk
// - first address byte zero goes to the configuration port
// - malformed configuration command sets an error flag and is discarded
// - packets whose address maps to no valid destination are dropped
// - table entries reset invalid; a packet to an invalid entry is spilled
// - entry holds a port set; whichever port of the set is free is used
// - logical address is looked up; forwarding waits for the chosen port
// - entry carries priority and header deletion; deletion strips address byte
// - high priority requests win over low ones, two levels only
// - equal priority requesters share an output fairly
// - crossbar lets disjoint input and output pairs run at once
// - link error closes the affected packet with error end or spills it
// - link error bits stay set until a configuration command clears them
// - slave: received code equal to stored plus one gives a tick-out
// - propagated time-code goes to every enabled link except the arrival link
// - other received codes load the time register without tick-out
// - master: auto mode counts per tick-in, normal mode sends time input
// - control bits and table are written only by configuration commands
// - a disabled link releases its transmit outputs to high impedance
// - bit 8 clear is data; set with bit 0 clear is EOP, else EEP
// - output FIFO shows active-low empty flag; host pops with low strobe
// - input FIFO shows active-low full flag; host pushes with low strobe
// - asynchronous active-low reset clears the whole device
package spr_pkg;
    localparam int NP = 11;
    localparam int PW = 4;
    localparam int NL = 8;
    localparam int NH = 2;
    localparam int WW = 9;
    localparam int TW = 6;
    localparam int LINK0 = 1;
    localparam int HOST0 = 9;
    localparam int PATH_MAX = 10;
    localparam int LOGICAL_MIN = 32;
    localparam int RT_N = 256;
    localparam int FIFO_DEPTH = 4;
    localparam int MARK_BIT = 8;
    localparam int EEP_BIT = 0;
    localparam logic [8:0] EEP_WORD = 9'h101;
    localparam logic [7:0] CMD_RT = 8'h01;
    localparam logic [7:0] CMD_LINK = 8'h02;
    localparam logic [7:0] CMD_CLR = 8'h03;
    localparam logic [7:0] CMD_TIME = 8'h04;
    localparam logic [7:0] CMD_CLR_CFG = 8'h05;
    localparam logic [2:0] LEN_RT = 3'h4;
    localparam logic [2:0] LEN_LINK = 3'h3;
    localparam logic [2:0] LEN_CLR = 3'h2;
    localparam logic [2:0] LEN_TIME = 3'h2;
    localparam logic [2:0] LEN_CFG = 3'h1;
    localparam logic [2:0] CNT_MAX = 3'h7;
    localparam int FL_VALID = 7;
    localparam int FL_PRI = 6;
    localparam int FL_DEL = 5;
    localparam int MASK_HI = 2;
    localparam int LINK_EN_BIT = 0;
    localparam int TM_MASTER = 0;
    localparam int TM_AUTO = 1;
    typedef enum logic [2:0] {IN_HEAD, IN_REQ, IN_XFER, IN_SPILL, IN_EEP} spr_in_st_t;
    typedef struct packed {
        logic valid;
        logic pri;
        logic del;
        logic [NP-1:0] mask;
    } spr_rt_t;
endpackage

// *** core/spr_arb.sv ***
// two-level round-robin arbiter for one output port
module spr_arb (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // requests
    input wire logic [spr_pkg::NP-1:0] req_hi,
    input wire logic [spr_pkg::NP-1:0] req_lo,
    input wire logic free,
    // packet completion
    input wire logic rel,
    input wire logic [spr_pkg::PW-1:0] rel_src,
    // grant
    output logic gnt,
    output logic [spr_pkg::PW-1:0] gnt_idx
);
    localparam int NP = spr_pkg::NP;
    localparam int PW = spr_pkg::PW;
    typedef struct packed {
        logic [PW-1:0] ptr;
    } spr_arb_st_t;
    spr_arb_st_t r_reg;
    spr_arb_st_t r_next;
    logic [PW:0] pick_hi;
    logic [PW:0] pick_lo;

    // first request after the pointer, wrapping
    function automatic logic [PW:0] spr_rr(input logic [NP-1:0] req, input logic [PW-1:0] ptr);
        logic [PW:0] res;
        int idx;
        res = '0;
        for (int k = NP; k >= 1; k--) begin
            idx = (int'(ptr) + k) % NP;
            if (req[idx]) begin
                res = {1'b1, idx[PW-1:0]};
            end
        end
        return res;
    endfunction

    always_comb begin
        r_next = r_reg;
        pick_hi = spr_rr(req_hi, r_reg.ptr);
        pick_lo = spr_rr(req_lo, r_reg.ptr);
        gnt = free & (pick_hi[PW] | pick_lo[PW]);
        gnt_idx = pick_hi[PW] ? pick_hi[PW-1:0] : pick_lo[PW-1:0];
        if (rel) begin
            r_next.ptr = rel_src;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// *** core/spr_fifo.sv ***
// first-word-fall-through FIFO for one host direction
module spr_fifo (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [spr_pkg::WW-1:0] in_word,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [spr_pkg::WW-1:0] out_word
);
    localparam int AW = $clog2(spr_pkg::FIFO_DEPTH);
    localparam logic [AW:0] FULL_CNT = spr_pkg::FIFO_DEPTH[AW:0];
    typedef struct packed {
        logic [spr_pkg::FIFO_DEPTH-1:0][spr_pkg::WW-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } spr_fifo_st_t;
    spr_fifo_st_t r_reg;
    spr_fifo_st_t r_next;
    logic push;
    logic pop;

    always_comb begin
        r_next = r_reg;
        in_ready = r_reg.cnt != FULL_CNT;
        out_valid = r_reg.cnt != '0;
        out_word = r_reg.mem[r_reg.rp];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        if (push) begin
            r_next.mem[r_reg.wp] = in_word;
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// *** dv/spr_router_properties.sv ***
// port-level assertions for the packet router
module spr_router_props (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // watched ports
    input wire logic [7:0] link_tx_valid,
    input wire logic [7:0] link_tx_oe_n,
    input wire logic [7:0] link_enable,
    input wire logic [7:0] link_error,
    input wire logic [7:0] link_error_status,
    input wire logic [7:0] link_tc_tx_valid,
    input wire logic [5:0] link_tc_tx_value,
    input wire logic tick_out,
    input wire logic [5:0] time_out,
    input wire logic [1:0] host_tx_fifo_has_room_n,
    input wire logic [1:0][8:0] host_rx_fifo_word,
    input wire logic [1:0] host_rx_fifo_has_word_n,
    input wire logic [1:0] host_rx_fifo_pop_n
);
    timeunit 1ns / 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_err_latched;
        ##1 link_error_status[0];
    endsequence
    property p_rst;
        $rose(arst_n) |-> link_enable == 8'hFF && host_tx_fifo_has_room_n == 2'h3 && host_rx_fifo_has_word_n == 2'h0;
    endproperty
    property p_oe;
        link_tx_oe_n == ~link_enable;
    endproperty
    property p_gate;
        (link_tx_valid & ~link_enable) == 8'h00;
    endproperty
    property p_err;
        link_error[0] |-> s_err_latched;
    endproperty
    property p_tcv;
        link_tc_tx_valid != 8'h00 |-> link_tc_tx_value == time_out;
    endproperty
    property p_tct;
        link_tc_tx_valid != 8'h00 |-> tick_out;
    endproperty
    property p_tce;
        (link_tc_tx_valid & ~link_enable) == 8'h00;
    endproperty
    property p_hold;
        host_rx_fifo_has_word_n[1] && host_rx_fifo_pop_n[1] |=> $stable(host_rx_fifo_word[1]);
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    a_oe: assert property (p_oe) else $error("oe vs enable");
    a_gate: assert property (p_gate) else $error("tx on disabled link");
    a_err: assert property (p_err) else $error("error not latched");
    a_tcv: assert property (p_tcv) else $error("code value");
    a_tct: assert property (p_tct) else $error("code without tick");
    a_tce: assert property (p_tce) else $error("code on disabled link");
    a_hold: assert property (p_hold) else $error("word moved");
endmodule

// *** dv/spr_far_model.sv ***
// far nodes and host: sink link words, drain host FIFOs
module spr_far_model (
    // clock and pace
    input wire logic mclk,
    input wire logic slow,
    // link transmit side
    input wire logic [7:0] link_tx_valid,
    input wire logic [7:0][8:0] link_tx_word,
    output logic [7:0] link_tx_ready = 8'hFF,
    // host output FIFOs
    input wire logic [1:0] host_rx_fifo_has_word_n,
    input wire logic [1:0][8:0] host_rx_fifo_word,
    output logic [1:0] host_rx_fifo_pop_n = 2'h3
);
    timeunit 1ns / 1ps;
    logic [8:0] got[$];
    always @(posedge mclk) begin
        for (int j = 0; j < 8; j++) begin
            if (link_tx_valid[j] && link_tx_ready[j]) got.push_back(link_tx_word[j]);
        end
        for (int j = 0; j < 2; j++) begin
            if (!host_rx_fifo_pop_n[j] && host_rx_fifo_has_word_n[j]) got.push_back(host_rx_fifo_word[j]);
        end
        // slow mode stalls every other cycle
        link_tx_ready <= slow ? ~link_tx_ready : 8'hFF;
        host_rx_fifo_pop_n <= ~host_rx_fifo_has_word_n;
    end
endmodule

// *** dv/spr_router_test.sv ***
// self-checking bench for the packet router
module spr_router_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic slow = 1'b0;
    logic tick_in = 1'b0;
    logic tick_out, cfg_error;
    logic [5:0] time_in = 6'h00, time_out, link_tc_tx_value;
    logic [7:0] link_rx_valid = 8'h00, link_error = 8'h00, link_tc_rx_valid = 8'h00;
    logic [7:0] link_rx_ready, link_tx_valid, link_tx_ready, link_tx_oe_n, link_enable, link_error_status;
    logic [7:0] link_tc_tx_valid;
    logic [7:0][8:0] link_rx_word = '0, link_tx_word;
    logic [7:0][5:0] link_tc_rx_value = '0;
    logic [1:0] host_tx_fifo_push_n = 2'h3, host_tx_fifo_has_room_n, host_rx_fifo_pop_n, host_rx_fifo_has_word_n;
    logic [1:0][8:0] host_tx_fifo_word = '0, host_rx_fifo_word;
    int fail_count = 0;
    int n_tests = 0;
    always #2 mclk = ~mclk;
    spr_router spr_router_i (.*);
    spr_far_model spr_far_model_i (.*);
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkq(input string nm, input logic [8:0] e);
        chk(nm, e, spr_far_model_i.got.size() ? spr_far_model_i.got.pop_front() : 9'hXXX);
    endtask
    task automatic send(input bit h, input int i, input logic [8:0] p[$]);
        foreach (p[k]) begin
            host_tx_fifo_word[i] <= p[k];
            link_rx_word[i] <= p[k];
            if (h) host_tx_fifo_push_n[i] <= 1'b0;
            else link_rx_valid[i] <= 1'b1;
            @(posedge mclk);
            while ((h ? host_tx_fifo_has_room_n[i] : link_rx_ready[i]) !== 1'b1) @(posedge mclk);
        end
        host_tx_fifo_push_n[i] <= 1'b1;
        link_rx_valid[i] <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask
    task automatic tcode(input logic [5:0] v, input logic [8:0] e);
        logic [8:0] seen = 9'h000;
        link_tc_rx_value[2] <= v;
        link_tc_rx_valid[2] <= 1'b1;
        @(posedge mclk);
        link_tc_rx_valid[2] <= 1'b0;
        repeat (4) begin
            @(posedge mclk);
            if (tick_out === 1'b1) seen = {1'b1, link_tc_tx_valid};
        end
        chk("tick_codes", e, seen);
        chk("time_out", {3'h0, v}, {3'h0, time_out});
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk("oe_enable", 9'h0FF, {link_tx_oe_n[0], link_enable});
        chk("fifo_flags", 9'h00C, {5'h00, host_tx_fifo_has_room_n, host_rx_fifo_has_word_n});
        $display("test reset ended");
        slow <= 1'b1;
        send(1, 0, '{9'h002, 9'h0A5, 9'h100});
        chkq("link1_data", 9'h0A5);
        chkq("link1_eop", 9'h100);
        slow <= 1'b0;
        send(0, 0, '{9'h00A, 9'h05A, 9'h101});
        chkq("host1_data", 9'h05A);
        chkq("host1_eep", 9'h101);
        $display("test route ended");
        send(1, 0, '{9'h000, 9'h002, 9'h003, 9'h101});
        chk("cfg_err_set", 9'h001, {8'h00, cfg_error});
        send(1, 0, '{9'h000, 9'h005, 9'h100});
        chk("cfg_err_clr", 9'h000, {8'h00, cfg_error});
        send(1, 0, '{9'h000, 9'h002, 9'h003, 9'h000, 9'h100});
        chk("link3_off", 9'h008, {1'b0, link_tx_oe_n});
        send(0, 1, '{9'h020, 9'h011, 9'h100});
        chk("spilled", 9'h000, 9'(spr_far_model_i.got.size()));
        send(1, 0, '{9'h000, 9'h001, 9'h020, 9'h0A0, 9'h004, 9'h100});
        send(0, 0, '{9'h020, 9'h033, 9'h100});
        chkq("hdr_deleted", 9'h033);
        chkq("table_eop", 9'h100);
        $display("test config ended");
        link_error[0] <= 1'b1;
        @(posedge mclk);
        link_error[0] <= 1'b0;
        repeat (5) @(posedge mclk);
        chk("err_sticky", 9'h001, {8'h00, link_error_status[0]});
        send(1, 0, '{9'h000, 9'h003, 9'h000, 9'h100});
        chk("err_clear", 9'h000, {8'h00, link_error_status[0]});
        tcode(6'h01, 9'h1F3);
        tcode(6'h05, 9'h000);
        send(1, 0, '{9'h000, 9'h004, 9'h003, 9'h100});
        tick_in <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("master", 9'h006, 9'(time_out));
        $display("test time ended");
        report_and_stop();
    end
    initial begin
        #20000;
        fail_count++;
        report_and_stop();
    end
endmodule
bind spr_router spr_router_props spr_router_props_i (.*);
